/* common/pd_wake_pkg.sv */
// Shared constants, types and register map of the power-down and wake controller.
package pd_wake_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;
   // Nominal watchdog period without prescaler, in microseconds.
   localparam int WDT_PERIOD_US = 18000;
   localparam int WDT_PERIOD_CYC = WDT_PERIOD_US * CYC_PER_US;
   // Oscillator driver restart time, in microseconds.
   localparam int OSC_START_US = 1;
   localparam int OSC_START_CYC = (OSC_START_US * CYC_PER_US < 1) ? 1 : OSC_START_US * CYC_PER_US;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_OPTION = 16'h0081;
   localparam logic [15:0] IDX_FUSES = 16'h2007;
   localparam logic [15:0] IDX_PD_STATUS = 16'h0010;
   localparam logic [15:0] IDX_EV_STATUS = 16'h0011;
   localparam logic [15:0] IDX_EV_MASK = 16'h0012;
   localparam logic [15:0] ADDR_OPTION = IDX_OPTION << 2;
   localparam logic [15:0] ADDR_FUSES = IDX_FUSES << 2;
   localparam logic [15:0] ADDR_PD_STATUS = IDX_PD_STATUS << 2;
   localparam logic [15:0] ADDR_EV_STATUS = IDX_EV_STATUS << 2;
   localparam logic [15:0] ADDR_EV_MASK = IDX_EV_MASK << 2;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [5:0] EV_MASK_RESET = 6'h00;
   localparam int OPT_PRESCALE_BIT = 3;
   localparam int OPT_PS_LSB = 0;
   localparam int FUSE_WDOG_EN_BIT = 2;
   localparam int PD_FLAG_BIT = 0;
   localparam int TO_FLAG_BIT = 1;
   localparam int PD_STATE_LSB = 2;
   // Event bits of the sticky status and mask registers.
   localparam int EV_SLEEP = 0;
   localparam int EV_WAKE_IRQ = 1;
   localparam int EV_WAKE_WDT = 2;
   localparam int EV_WAKE_BUS = 3;
   localparam int EV_WDT_RESET = 4;
   localparam int EV_CLEAR_PIN = 5;
   localparam int EV_W = 6;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_OSC_RESTART = 4'b0100,
      ST_RESUME = 4'b1000
   } pd_state_e;

   // One bit per interrupt source able to wake the core.
   typedef struct packed {
      logic comparator;
      logic port_change;
      logic edge_pin;
   } irq_src_s;

endpackage

/* verilog/watchdog_timer.sv */
// Watchdog counter with optional power-of-two prescaler.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
   import pd_wake_pkg::*;
#(
   parameter int PERIOD_CYC = WDT_PERIOD_CYC
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic enable_in,
   input wire logic clear_in,
   input wire logic prescale_on_in,
   input wire logic [2:0] ps_in,
   output logic timeout_out
);
   localparam int CW = $clog2(PERIOD_CYC + 1);

   logic [CW-1:0] base_count;
   logic [6:0] post_count;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // The base tick stands in for the free-running watchdog oscillator.
   wire base_tick = base_count == CW'(PERIOD_CYC - 1);
   wire [7:0] ratio = prescale_on_in ? (8'h01 << ps_in) : 8'h01;
   wire [6:0] ratio_m1 = 7'(ratio - 8'h01);
   // A ratio cut short by a reprogram still fires rather than wrapping.
   wire fire = enable_in & base_tick & (post_count >= ratio_m1);

   // Count, cleared together with the prescaler by any clear request.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in || clear_in || !enable_in) begin
         base_count <= '0;
         post_count <= '0;
      end else if (base_tick) begin
         base_count <= '0;
         post_count <= fire ? 7'h00 : 7'(post_count + 7'h01);
      end else begin
         base_count <= CW'(base_count + 1'b1);
      end
   end

   // Registered one-cycle timeout pulse.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in || clear_in) begin
         timeout_out <= 1'b0;
      end else begin
         timeout_out <= fire;
      end
   end
endmodule
`default_nettype wire

/* verilog/power_down_wake_control.sv */
// Power-down entry, wake-up and watchdog control of a small core.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Low-power state is entered only on the power-down instruction.
// - Entry clears watchdog count, clears power-down flag, sets timeout flag, stops oscillator.
// - Port pins keep their drive state while powered down.
// - Watchdog reset stays internal; master clear pin is never driven.
// - Wake on master clear, watchdog timeout, enabled interrupt or bus activity.
// - Master clear wake fully resets; interrupt wakes continue the program.
// - Power-down flag set at power-up, cleared by the power-down instruction.
// - A watchdog wake clears the timeout flag.
// - The next instruction is prefetched during the power-down instruction.
// - Only the source's own enable gates a wake, not global enable.
// - Global enable off resumes inline; on, runs prefetch then vectors to 0004h.
// - A source already enabled and flagged makes power-down wake at once.
// - Every wake clears the watchdog count.
// - Watchdog timeout resets in normal run, wakes during power-down.
// - Watchdog-clear or power-down instruction clears count and assigned prescaler.
module power_down_wake_control
   import pd_wake_pkg::*;
#(
   parameter int WDT_PERIOD = WDT_PERIOD_CYC
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core side.
   input wire logic sleep_instr_in,
   input wire logic watchdog_clear_instr_in,
   input wire logic global_irq_enable_in,
   input wire irq_src_s irq_enable_in,
   input wire irq_src_s irq_flag_in,
   input wire logic [7:0] config_fuses_in,
   // Pins.
   input wire logic master_clear_pin_in,
   input wire logic bus_activity_in,
   // Outputs.
   output logic core_run_out,
   output logic prefetch_out,
   output logic resume_out,
   output logic vector_irq_out,
   output logic [12:0] vector_addr_out,
   output logic device_reset_out,
   output logic osc_driver_en_out,
   output logic port_hold_out,
   output logic power_down_flag_out,
   output logic timeout_flag_out,
   output logic irq_out
);
   pd_state_e state;
   pd_state_e next_state;
   logic [7:0] option_control;
   logic [7:0] config_word_fuses;
   logic fuses_loaded;
   logic power_down_flag;
   logic timeout_flag;
   logic [EV_W-1:0] ev_status;
   logic [EV_W-1:0] ev_mask;
   logic [31:0] rd_data;
   logic [15:0] osc_count;
   logic wake_by_irq;
   logic [2:0] clr_pin_sync;
   logic [2:0] bus_sync;
   logic clr_pin_level;
   logic bus_level;
   logic bus_level_d;
   logic wdt_timeout;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; the filtered level follows only when stages two and three agree.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         clr_pin_sync <= 3'b111;
         bus_sync <= 3'b000;
         clr_pin_level <= 1'b1;
         bus_level <= 1'b0;
         bus_level_d <= 1'b0;
      end else begin
         clr_pin_sync <= {clr_pin_sync[1:0], master_clear_pin_in};
         bus_sync <= {bus_sync[1:0], bus_activity_in};
         if (clr_pin_sync[1] == clr_pin_sync[2]) begin
            clr_pin_level <= clr_pin_sync[2];
         end
         if (bus_sync[1] == bus_sync[2]) begin
            bus_level <= bus_sync[2];
         end
         bus_level_d <= bus_level;
      end
   end

   // ----------------------------------------------------------------
   // Decode of core requests and wake sources
   // ----------------------------------------------------------------
   wire in_run = state == ST_RUN;
   wire in_sleep = state == ST_SLEEP;
   wire clr_pin_reset = !clr_pin_level;
   wire bus_wake = bus_level & !bus_level_d;
   wire wdt_enabled = config_word_fuses[FUSE_WDOG_EN_BIT];
   wire sleep_take = in_run & sleep_instr_in & !clr_pin_reset;
   // Global enable plays no part in whether a source may wake the core.
   wire irq_pending = |(irq_enable_in & irq_flag_in);
   wire wake_wdt = in_sleep & wdt_timeout;
   wire wake_irq = in_sleep & irq_pending & !wdt_timeout;
   wire wake_any = wdt_timeout | irq_pending | bus_wake;
   wire wdt_run_reset = in_run & wdt_timeout;
   // Clearing the watchdog on entry, on every wake and on its own instruction.
   wire wdt_clear = sleep_take | (in_sleep & wake_any) | (in_run & watchdog_clear_instr_in)
                    | clr_pin_reset;
   wire osc_done = osc_count == 16'(OSC_START_CYC - 1);

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   watchdog_timer #(
      .PERIOD_CYC(WDT_PERIOD)
   ) u_watchdog (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .enable_in(wdt_enabled),
      .clear_in(wdt_clear),
      .prescale_on_in(option_control[OPT_PRESCALE_BIT]),
      .ps_in(option_control[OPT_PS_LSB +: 3]),
      .timeout_out(wdt_timeout)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Sleep holds only while master clear stays high; a low level resets the sequence.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (sleep_take) begin
               // A source already pending finishes the instruction and wakes.
               next_state = irq_pending ? ST_RESUME : ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_any) begin
               next_state = ST_OSC_RESTART;
            end
         end
         ST_OSC_RESTART: begin
            if (osc_done) begin
               next_state = ST_RESUME;
            end
         end
         ST_RESUME: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // State register; master clear forces a full restart in run.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in || clr_pin_reset) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Oscillator start-up timer, counting only while restarting.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in || state != ST_OSC_RESTART) begin
         osc_count <= 16'h0000;
      end else begin
         osc_count <= 16'(osc_count + 16'h0001);
      end
   end

   // Remember whether an interrupt source caused the wake.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         wake_by_irq <= 1'b0;
      end else if (sleep_take) begin
         wake_by_irq <= irq_pending;
      end else if (in_sleep && wake_any) begin
         wake_by_irq <= wake_irq;
      end
   end

   // ----------------------------------------------------------------
   // Status flags (both active low in meaning: cleared marks the event)
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (wdt_timeout && (in_run || in_sleep)) begin
         // Cleared on a timeout in run or sleep so software can tell the cause.
         timeout_flag <= 1'b0;
         // The power-down instruction still clears its own flag in the same cycle.
         if (sleep_take) begin
            power_down_flag <= 1'b0;
         end
      end else if (sleep_take) begin
         power_down_flag <= 1'b0;
         timeout_flag <= 1'b1;
      end else if (in_run && watchdog_clear_instr_in) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end
   end

   // Fuses are read-only and captured once after reset release.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         config_word_fuses <= 8'h00;
         fuses_loaded <= 1'b0;
      end else if (!fuses_loaded) begin
         config_word_fuses <= config_fuses_in;
         fuses_loaded <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   wire setup = psel & !penable;
   wire access = psel & penable;
   wire hit_option = paddr == ADDR_OPTION;
   wire hit_fuses = paddr == ADDR_FUSES;
   wire hit_pd = paddr == ADDR_PD_STATUS;
   wire hit_ev = paddr == ADDR_EV_STATUS;
   wire hit_mask = paddr == ADDR_EV_MASK;
   wire hit_any = hit_option | hit_fuses | hit_pd | hit_ev | hit_mask;
   // Fuses and the flag register are read-only; a write to them is an error.
   wire wr_ok = hit_option | hit_ev | hit_mask;
   wire wr_en = access & pwrite & wr_ok;
   wire [EV_W-1:0] ev_clear = (wr_en && hit_ev) ? pwdata[EV_W-1:0] : '0;
   wire [EV_W-1:0] ev_set = {clr_pin_reset, wdt_run_reset,
                             wake_wdt ? 1'b0 : (in_sleep & bus_wake & !irq_pending),
                             wake_wdt, wake_irq, sleep_take};

   assign pready = access;
   assign pslverr = access & (pwrite ? !wr_ok : !hit_any);

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      rd_data = 32'h0000_0000;
      if (hit_option) begin
         rd_data[7:0] = option_control;
      end else if (hit_fuses) begin
         rd_data[7:0] = config_word_fuses;
      end else if (hit_pd) begin
         rd_data[PD_FLAG_BIT] = power_down_flag;
         rd_data[TO_FLAG_BIT] = timeout_flag;
         rd_data[PD_STATE_LSB +: 4] = state;
      end else if (hit_ev) begin
         rd_data[EV_W-1:0] = ev_status;
      end else if (hit_mask) begin
         rd_data[EV_W-1:0] = ev_mask;
      end
   end

   // Read data is captured in the setup cycle and stands through the access.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= rd_data;
      end
   end

   // Writable registers.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         option_control <= OPTION_RESET;
         ev_mask <= EV_MASK_RESET;
      end else if (wr_en) begin
         if (hit_option) begin
            option_control <= pwdata[7:0];
         end
         if (hit_mask) begin
            ev_mask <= pwdata[EV_W-1:0];
         end
      end
   end

   // Sticky events, write one to clear; a new event wins over its clear.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         ev_status <= '0;
      end else begin
         ev_status <= (ev_status & ~ev_clear) | ev_set;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign core_run_out = in_run;
   // The following word is fetched while the power-down instruction executes.
   assign prefetch_out = sleep_take;
   assign resume_out = state == ST_RESUME;
   // With global enable set, the core runs the prefetched word, then vectors.
   assign vector_irq_out = resume_out & wake_by_irq & global_irq_enable_in;
   assign vector_addr_out = IRQ_VECTOR;
   // Watchdog reset is an internal pulse only; there is no drive onto master clear.
   assign device_reset_out = clr_pin_reset | wdt_run_reset;
   assign osc_driver_en_out = !in_sleep;
   // Pin drivers freeze high, low or released while asleep or restarting.
   assign port_hold_out = in_sleep | (state == ST_OSC_RESTART);
   assign power_down_flag_out = power_down_flag;
   assign timeout_flag_out = timeout_flag;
   assign irq_out = |(ev_status & ev_mask);
endmodule
`default_nettype wire

/* tb/pd_wake_props.sv */
// Port-level concurrent checks of the power-down and wake controller.
`timescale 1ns/1ps
`default_nettype none
module pd_wake_props
   import pd_wake_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic sleep_instr_in,
   input wire irq_src_s irq_enable_in,
   input wire irq_src_s irq_flag_in,
   input wire logic core_run_out,
   input wire logic prefetch_out,
   input wire logic resume_out,
   input wire logic vector_irq_out,
   input wire logic [12:0] vector_addr_out,
   input wire logic device_reset_out,
   input wire logic osc_driver_en_out,
   input wire logic port_hold_out,
   input wire logic power_down_flag_out,
   input wire logic timeout_flag_out
);
   // ------
   // Clocking and helpers
   // ------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // A source counts only when its own enable and its flag are both set.
   wire logic pending = |(irq_enable_in & irq_flag_in);
   // Asleep means oscillator off with the pins frozen.
   sequence asleep_seq;
      !osc_driver_en_out && port_hold_out;
   endsequence
   // The core stays stopped until the restart count has run out.
   sequence restart_seq;
      !core_run_out ##20 (resume_out && !core_run_out) ##1 core_run_out;
   endsequence
   // ------
   // Properties
   // ------
   AST_RUN_HOLDS: assert property (core_run_out && !sleep_instr_in |=> core_run_out)
      else $error("core stopped without the power-down instruction");
   AST_PREFETCH: assert property (sleep_instr_in && core_run_out && !device_reset_out |-> prefetch_out)
      else $error("no prefetch on the power-down instruction");
   AST_ENTRY_FLAGS: assert property (prefetch_out |=> !power_down_flag_out && timeout_flag_out)
      else $error("flags wrong after power-down entry");
   AST_OSC_OFF: assert property (prefetch_out && !pending |=> asleep_seq)
      else $error("oscillator not stopped on entry");
   AST_HOLD_ASLEEP: assert property (!osc_driver_en_out |-> port_hold_out && !core_run_out)
      else $error("pins not held while asleep");
   AST_OSC_RESTART: assert property ($rose(osc_driver_en_out) && port_hold_out |-> restart_seq)
      else $error("resume not after oscillator restart");
   AST_VECTOR: assert property (vector_irq_out |-> resume_out && vector_addr_out == 13'h0004)
      else $error("vector outside resume or wrong address");
   AST_PENDING: assert property (prefetch_out && pending |=> resume_out)
      else $error("pending source did not wake at once");
   AST_IRQ_WAKE: assert property (asleep_seq ##0 pending |=> osc_driver_en_out)
      else $error("enabled source did not wake");
   AST_CLR_PIN_WAKE: assert property (asleep_seq ##0 device_reset_out |-> ##[1:2] core_run_out)
      else $error("master clear did not reset out of sleep");
endmodule
bind power_down_wake_control pd_wake_props i_pd_wake_props (.sys_clk_in, .reset_n_in,
   .sleep_instr_in, .irq_enable_in, .irq_flag_in, .core_run_out, .prefetch_out, .resume_out,
   .vector_irq_out, .vector_addr_out, .device_reset_out, .osc_driver_en_out, .port_hold_out,
   .power_down_flag_out, .timeout_flag_out);
`default_nettype wire

/* tb/wake_source_model.sv */
// Model of the reset pin, bus line and interrupt sources outside the controller.
`timescale 1ns/1ps
`default_nettype none
module wake_source_model
   import pd_wake_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic clear_low_req_in,
   input wire logic bus_req_in,
   input wire irq_src_s flag_req_in,
   output var logic master_clear_pin_out,
   output var logic bus_activity_out,
   output var irq_src_s irq_flag_out
);
   logic [2:0] bus_count;
   // Idle levels from time zero: pin released high, bus quiet, no flags.
   initial begin
      master_clear_pin_out = 1'b1;
      bus_activity_out = 1'b0;
      irq_flag_out = '0;
      bus_count = 3'h0;
   end
   // Bus bursts last four cycles so the synchroniser cannot miss them.
   always @(posedge sys_clk_in) begin
      master_clear_pin_out <= !clear_low_req_in;
      irq_flag_out <= flag_req_in;
      if (bus_req_in)
         bus_count <= 3'h4;
      else if (bus_count != 3'h0)
         bus_count <= bus_count - 3'h1;
      bus_activity_out <= (bus_count != 3'h0);
   end
endmodule
`default_nettype wire

/* tb/test_power_down_wake_control.sv */
// Self-checking bench of the power-down and wake controller.
`timescale 1ns/1ps
`default_nettype none
module test_power_down_wake_control
   import pd_wake_pkg::*;
;
   localparam int PERIOD = 50;
   localparam int LIMIT = 20000;
   logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_instr = 1'b0, wd_clear = 1'b0, glob_en = 1'b0, clr_req = 1'b0, bus_req = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   irq_src_s irq_en = '0, flag_req = '0;
   irq_src_s irq_flag;
   logic [31:0] prdata, rd;
   logic [12:0] vec_addr;
   logic pready, pslverr, clr_pin, bus_act, core_run, prefetch, resume, vec_irq, dev_reset;
   logic osc_en, port_hold, pd_flag, to_flag, irq, err, vec;
   int mismatches = 0, check_count = 0, n;

   // Free-running 20 MHz clock.
   always #25 sys_clk = ~sys_clk;

   // ------
   // Design and far-side model
   // ------
   power_down_wake_control #(.WDT_PERIOD(PERIOD)) i_power_down_wake_control (.sys_clk_in(sys_clk),
      .reset_n_in(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_instr_in(sleep_instr), .watchdog_clear_instr_in(wd_clear),
      .global_irq_enable_in(glob_en), .irq_enable_in(irq_en), .irq_flag_in(irq_flag),
      .config_fuses_in(8'h04), .master_clear_pin_in(clr_pin), .bus_activity_in(bus_act),
      .core_run_out(core_run), .prefetch_out(prefetch), .resume_out(resume),
      .vector_irq_out(vec_irq), .vector_addr_out(vec_addr), .device_reset_out(dev_reset),
      .osc_driver_en_out(osc_en), .port_hold_out(port_hold), .power_down_flag_out(pd_flag),
      .timeout_flag_out(to_flag), .irq_out(irq));
   wake_source_model i_wake_source_model (.sys_clk_in(sys_clk), .clear_low_req_in(clr_req),
      .bus_req_in(bus_req), .flag_req_in(flag_req), .master_clear_pin_out(clr_pin),
      .bus_activity_out(bus_act), .irq_flag_out(irq_flag));

   // ------
   // Shared tasks
   // ------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request stands until pready is seen at an edge.
   task apb(input logic [15:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // No wait-state count is assumed; only the run watchdog ends a hung wait.
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task do_sleep;
      @(posedge sys_clk);
      sleep_instr <= 1'b1;
      @(posedge sys_clk);
      chk(prefetch, 1);
      // The word after the power-down instruction is a no-op here.
      sleep_instr <= 1'b0;
   endtask
   // Bounded waits; a one-cycle pulse is caught because every edge is sampled.
   task wait_resume(input int lim);
      n = 0;
      while (resume !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n < lim, 1);
      vec = vec_irq;
   endtask
   task wait_reset(input int lim);
      n = 0;
      while (dev_reset !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   // ------
   // Scenarios
   // ------
   task t_regs;
      apb(ADDR_OPTION, 1'b0, 32'h0);
      chk(rd, 32'h0000_00ff);
      apb(ADDR_PD_STATUS, 1'b0, 32'h0);
      chk(rd, 32'h0000_0007);
      apb(ADDR_FUSES, 1'b0, 32'h0);
      chk(rd, 32'h0000_0004);
      apb(ADDR_FUSES, 1'b1, 32'h0);
      chk(err, 1);
      apb(16'h0100, 1'b0, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
   endtask
   // A disabled source must not wake; the enabled one must, vectoring per gie.
   task t_irq(input logic g, input irq_src_s en, input irq_src_s off);
      @(posedge sys_clk);
      glob_en <= g;
      irq_en <= en;
      do_sleep;
      flag_req <= off;
      repeat (30) @(posedge sys_clk);
      chk({osc_en, port_hold, pd_flag, to_flag}, 32'h5);
      flag_req <= en;
      wait_resume(40);
      chk(vec, g);
      chk(vec_addr, 13'h0004);
      flag_req <= '0;
      irq_en <= '0;
      @(negedge sys_clk);
      chk(core_run, 1);
   endtask
   task t_pending;
      @(posedge sys_clk);
      irq_en <= 3'h2;
      flag_req <= 3'h2;
      repeat (3) @(posedge sys_clk);
      do_sleep;
      wait_resume(3);
      irq_en <= '0;
      flag_req <= '0;
   endtask
   task t_bus;
      do_sleep;
      bus_req <= 1'b1;
      @(posedge sys_clk);
      bus_req <= 1'b0;
      wait_resume(40);
      chk(vec, 0);
   endtask
   task t_wdt;
      apb(ADDR_OPTION, 1'b1, 32'h0);
      do_sleep;
      wait_resume(PERIOD + 40);
      chk(to_flag, 0);
      wait_reset(PERIOD + 10);
      chk(n >= 20 && n < PERIOD + 10, 1);
      wd_clear <= 1'b1;
      @(posedge sys_clk);
      wd_clear <= 1'b0;
      @(negedge sys_clk);
      chk({pd_flag, to_flag}, 32'h3);
      apb(ADDR_OPTION, 1'b1, 32'h0000_00ff);
   endtask
   task t_events;
      apb(ADDR_EV_STATUS, 1'b0, 32'h0);
      chk({irq, rd[4:0]}, 32'h1f);
      apb(ADDR_EV_MASK, 1'b1, 32'h4);
      @(negedge sys_clk);
      chk(irq, 1);
      apb(ADDR_EV_STATUS, 1'b1, 32'h3f);
      @(negedge sys_clk);
      chk(irq, 0);
   endtask
   task t_clear_pin;
      do_sleep;
      clr_req <= 1'b1;
      wait_reset(10);
      chk(n < 10, 1);
      repeat (3) @(posedge sys_clk);
      chk({core_run, port_hold, osc_en}, 32'h5);
      clr_req <= 1'b0;
      repeat (8) @(posedge sys_clk);
      apb(ADDR_EV_STATUS, 1'b0, 32'h0);
      chk(rd[5], 1);
   endtask

   task stop_test;
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence: five reset cycles, then the scenarios in turn.
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_regs;
      t_irq(1'b0, 3'h4, 3'h2);
      t_irq(1'b1, 3'h1, 3'h2);
      t_pending;
      t_bus;
      t_wdt;
      t_events;
      t_clear_pin;
      stop_test;
   end
   // Watchdog of the run; the tests need a few hundred cycles.
   initial begin
      repeat (LIMIT) @(posedge sys_clk);
      mismatches++;
      stop_test;
   end
endmodule
`default_nettype wire
